// ==== src/plu_pkg.sv ====
package plu_pkg;

  localparam int ACC_W      = 32;
  localparam int HALF_W     = 16;
  localparam int ADDR_W     = 11;
  localparam int CNT_W      = 6;
  localparam int BITS_MIN   = 1;
  localparam int BITS_MAX   = 32;
  localparam int STACK_DEPTH = 8;

  // Highest legal starting location per discrete area (octal)
  localparam logic [ADDR_W-1:0] MAX_IO    = 11'o777;
  localparam logic [ADDR_W-1:0] MAX_RELAY = 11'o1777;
  localparam logic [ADDR_W-1:0] MAX_TIMER = 11'o377;
  localparam logic [ADDR_W-1:0] MAX_CTR   = 11'o177;
  localparam logic [ADDR_W-1:0] MAX_SPEC  = 11'o777;

  typedef enum logic [2:0] {
    PLU_AREA_IN,
    PLU_AREA_OUT,
    PLU_AREA_RELAY,
    PLU_AREA_STAGE,
    PLU_AREA_TIMER,
    PLU_AREA_CTR,
    PLU_AREA_SPEC
  } plu_area_t;

  typedef enum logic [2:0] {
    PLU_OP_NONE,
    PLU_OP_OR_BIT_RANGE,
    PLU_OP_OR_WITH_STACK,
    PLU_OP_XOR_WORD,
    PLU_OP_XOR_DOUBLE,
    PLU_OP_XOR_BIT_RANGE
  } plu_op_t;

  typedef struct packed {
    plu_op_t                op;
    plu_area_t              area;
    logic [ADDR_W-1:0]      start;
    logic [CNT_W-1:0]       count;
    logic [ACC_W-1:0]       operand;
  } plu_cmd_t;

  typedef struct packed {
    logic zero_result_flag;
    logic negative_result_flag;
  } plu_flags_t;

endpackage : plu_pkg

// ==== src/plu_logic_op_unit.sv ====
`timescale 1ns/1ps

// Behaviour
// - Bit-range OR combines accumulator with 1 to 32 discrete bits into accumulator.
// - Bit-range OR uses start location and constant count, exactly that many bits.
// - After bit-range OR, zero flag on zero result, negative on MSB.
// - Start location accepted within each discrete area's documented range.
// - Stack OR: 32-bit OR of accumulator with first stack level.
// - Stack OR pops first level; remaining entries move up one level.
// - After stack OR, zero and negative flags from 32-bit result.
// - Word XOR: low 16 accumulator bits XOR one word location.
// - After word XOR, zero flag on zero result; negative also updated.
// - Double XOR: 32-bit accumulator XOR word pair or constant.
// - After double XOR, zero flag on zero, negative on MSB.
// - Bit-range XOR: accumulator XOR 1 to 32 discrete bits from start and count.
// - After bit-range XOR, zero flag on zero, negative on MSB.
// - Zero flag on when result is zero, off otherwise.
// - Negative flag on when result MSB is set.
// - Flags hold until a later flag-driving instruction overwrites them.
module plu_logic_op_unit #(
  parameter int ACC_W       = plu_pkg::ACC_W,
  parameter int STACK_DEPTH = plu_pkg::STACK_DEPTH
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  input  wire logic                     cmd_valid,
  input  wire plu_pkg::plu_cmd_t        cmd,
  input  wire logic [plu_pkg::BITS_MAX-1:0] disc_bits,
  input  wire logic                     acc_load,
  input  wire logic [ACC_W-1:0]         acc_load_value,
  input  wire logic                     stack_push,
  output logic [ACC_W-1:0]              acc,
  output plu_pkg::plu_flags_t           flags,
  output logic [ACC_W-1:0]              stack_top,
  output logic                          done,
  output logic                          cmd_error
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  logic [ACC_W-1:0]  stack [STACK_DEPTH];
  logic [SP_W-1:0]   stack_used;
  logic [ACC_W-1:0]  range_mask;
  logic [ACC_W-1:0]  range_val;
  logic [ACC_W-1:0]  next_acc;
  logic              addr_ok;
  logic              count_ok;
  logic              is_range;
  logic              accept;
  logic              changes_acc;

  // Start location limit per discrete area
  always_comb begin
    unique case (cmd.area)
      plu_pkg::PLU_AREA_IN,
      plu_pkg::PLU_AREA_OUT:   addr_ok = cmd.start <= plu_pkg::MAX_IO;
      plu_pkg::PLU_AREA_RELAY,
      plu_pkg::PLU_AREA_STAGE: addr_ok = cmd.start <= plu_pkg::MAX_RELAY;
      plu_pkg::PLU_AREA_TIMER: addr_ok = cmd.start <= plu_pkg::MAX_TIMER;
      plu_pkg::PLU_AREA_CTR:   addr_ok = cmd.start <= plu_pkg::MAX_CTR;
      plu_pkg::PLU_AREA_SPEC:  addr_ok = cmd.start <= plu_pkg::MAX_SPEC;
      default:                 addr_ok = 1'b0;
    endcase
  end

  assign count_ok = (cmd.count >= plu_pkg::CNT_W'(plu_pkg::BITS_MIN)) &&
                    (cmd.count <= plu_pkg::CNT_W'(plu_pkg::BITS_MAX));

  assign is_range = (cmd.op == plu_pkg::PLU_OP_OR_BIT_RANGE) ||
                    (cmd.op == plu_pkg::PLU_OP_XOR_BIT_RANGE);

  assign accept = cmd_valid && (cmd.op != plu_pkg::PLU_OP_NONE) &&
                  (!is_range || (addr_ok && count_ok));

  // Keep only count bits, start location at bit 0
  genvar gi;
  generate
    for (gi = 0; gi < ACC_W; gi++) begin : g_mask
      assign range_mask[gi] = (gi < int'(cmd.count));
    end
  endgenerate

  assign range_val = disc_bits & range_mask;

  always_comb begin
    next_acc = acc;
    unique case (cmd.op)
      plu_pkg::PLU_OP_OR_BIT_RANGE:  next_acc = acc | range_val;
      plu_pkg::PLU_OP_OR_WITH_STACK: next_acc = acc | stack[0];
      plu_pkg::PLU_OP_XOR_WORD:
        next_acc = {acc[ACC_W-1:plu_pkg::HALF_W],
                    acc[plu_pkg::HALF_W-1:0] ^ cmd.operand[plu_pkg::HALF_W-1:0]};
      plu_pkg::PLU_OP_XOR_DOUBLE:    next_acc = acc ^ cmd.operand;
      plu_pkg::PLU_OP_XOR_BIT_RANGE: next_acc = acc ^ range_val;
      plu_pkg::PLU_OP_NONE:          next_acc = acc;
      default:                       next_acc = acc;
    endcase
  end

  assign changes_acc = accept;

  // Accumulator
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      acc <= '0;
    end else if (changes_acc) begin
      acc <= next_acc;
    end else if (acc_load) begin
      acc <= acc_load_value;
    end
  end

  // Status flags, held until the next logic instruction
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flags <= '0;
    end else if (changes_acc) begin
      flags.zero_result_flag     <= (next_acc == '0);
      flags.negative_result_flag <= next_acc[ACC_W-1];
    end
  end

  // Accumulator stack: push shifts down, stack OR pops and shifts up
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack[i] <= '0;
      end
      stack_used <= '0;
    end else if (changes_acc && cmd.op == plu_pkg::PLU_OP_OR_WITH_STACK) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stack[i] <= stack[i+1];
      end
      stack[STACK_DEPTH-1] <= '0;
      if (stack_used != '0) begin
        stack_used <= stack_used - SP_W'(1);
      end
    end else if (stack_push) begin
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stack[i] <= stack[i-1];
      end
      stack[0] <= acc;
      if (stack_used != SP_W'(STACK_DEPTH)) begin
        stack_used <= stack_used + SP_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stack_top <= '0;
    end else begin
      stack_top <= stack[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      done      <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      done      <= accept;
      cmd_error <= cmd_valid && !accept;
    end
  end

  a_flag_zero_track: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept |=> flags.zero_result_flag == (acc == '0))
    else $error("zero flag does not match result");

  a_flag_neg_track: assert property (@(posedge sys_clk) disable iff (!rst_b)
    accept |=> flags.negative_result_flag == acc[ACC_W-1])
    else $error("negative flag does not match result");

  a_flags_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !accept |=> $stable(flags))
    else $error("flags changed without an instruction");

  a_or_range_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accept && cmd.op == plu_pkg::PLU_OP_OR_BIT_RANGE)
      |=> acc == ($past(acc) | ($past(disc_bits) & $past(range_mask))))
    else $error("bit-range OR result wrong");

  a_range_count_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accept && is_range) |-> (range_val >> cmd.count) == '0)
    else $error("bits beyond count used");

  a_range_start_legal: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cmd_valid && is_range && cmd.area == plu_pkg::PLU_AREA_CTR
       && cmd.start > plu_pkg::MAX_CTR) |=> cmd_error && !done)
    else $error("out of range start accepted");

  a_stack_or_pop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accept && cmd.op == plu_pkg::PLU_OP_OR_WITH_STACK)
      |=> acc == ($past(acc) | $past(stack[0])) && stack[0] == $past(stack[1]))
    else $error("stack OR result or pop wrong");

  a_word_xor_upper: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accept && cmd.op == plu_pkg::PLU_OP_XOR_WORD)
      |=> acc[ACC_W-1:plu_pkg::HALF_W] == $past(acc[ACC_W-1:plu_pkg::HALF_W]))
    else $error("word XOR changed upper half");

  a_double_xor_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accept && cmd.op == plu_pkg::PLU_OP_XOR_DOUBLE)
      |=> acc == ($past(acc) ^ $past(cmd.operand)))
    else $error("double XOR result wrong");

  a_xor_range_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accept && cmd.op == plu_pkg::PLU_OP_XOR_BIT_RANGE)
      |=> acc == ($past(acc) ^ $past(range_val)))
    else $error("bit-range XOR result wrong");

endmodule : plu_logic_op_unit

// ==== tb/plu_logic_op_unit_tb_top.sv ====
`timescale 1ns/1ps
module plu_logic_op_unit_tb_top;
  localparam plu_pkg::plu_op_t   O_NO = plu_pkg::PLU_OP_NONE;
  localparam plu_pkg::plu_op_t   O_OR = plu_pkg::PLU_OP_OR_BIT_RANGE;
  localparam plu_pkg::plu_op_t   O_OS = plu_pkg::PLU_OP_OR_WITH_STACK;
  localparam plu_pkg::plu_op_t   O_XW = plu_pkg::PLU_OP_XOR_WORD;
  localparam plu_pkg::plu_op_t   O_XD = plu_pkg::PLU_OP_XOR_DOUBLE;
  localparam plu_pkg::plu_op_t   O_XR = plu_pkg::PLU_OP_XOR_BIT_RANGE;
  localparam plu_pkg::plu_area_t A_IN = plu_pkg::PLU_AREA_IN;
  logic                sys_clk, rst_b, cmd_valid, acc_load, stack_push, done, cmd_error;
  plu_pkg::plu_cmd_t   cmd;
  plu_pkg::plu_flags_t flags, m_flg;
  logic [31:0]         disc_bits, acc_load_value, acc, stack_top, m_acc;
  logic [31:0]         stk[$];
  int                  fails, samples_checked;

  plu_logic_op_unit plu_logic_op_unit_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd(cmd), .disc_bits(disc_bits), .acc_load(acc_load),
    .acc_load_value(acc_load_value), .stack_push(stack_push), .acc(acc), .flags(flags),
    .stack_top(stack_top), .done(done), .cmd_error(cmd_error));

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  function automatic logic [10:0] lim(plu_pkg::plu_area_t a);
    case (a)
      plu_pkg::PLU_AREA_RELAY, plu_pkg::PLU_AREA_STAGE: return plu_pkg::MAX_RELAY;
      plu_pkg::PLU_AREA_TIMER: return plu_pkg::MAX_TIMER;
      plu_pkg::PLU_AREA_CTR:   return plu_pkg::MAX_CTR;
      default:                 return plu_pkg::MAX_IO;
    endcase
  endfunction : lim

  task automatic load(logic [31:0] v);
    @(posedge sys_clk);
    acc_load       <= 1'b1;
    acc_load_value <= v;
    @(posedge sys_clk);
    acc_load <= 1'b0;
    m_acc = v;
  endtask : load

  task automatic issue(plu_pkg::plu_op_t op, plu_pkg::plu_area_t ar, logic [10:0] st,
                       logic [5:0] n, logic [31:0] opd, logic [31:0] d);
    logic        ok;
    logic [31:0] m, r;
    ok = op != O_NO;
    m = (n >= 6'h20) ? d : d & ((32'h1 << n) - 32'h1);
    if (op inside {O_OR, O_XR}) ok = ok && n != 6'h0 && n <= 6'h20 && st <= lim(ar);
    case (op)
      O_OR:    r = m_acc | m;
      O_XR:    r = m_acc ^ m;
      O_OS:    r = m_acc | ((stk.size() > 0) ? stk[0] : 32'h0);
      O_XW:    r = {m_acc[31:16], m_acc[15:0] ^ opd[15:0]};
      default: r = m_acc ^ opd;
    endcase
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd       <= '{op, ar, st, n, opd};
    disc_bits <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    disc_bits <= ~d;
    #1;
    if (ok) begin
      if (op == O_OS && stk.size() > 0) void'(stk.pop_front());
      m_acc = r;
      m_flg = {r == 32'h0, r[31]};
    end
    check("acc", acc, m_acc);
    check("flags", {30'h0, flags}, {30'h0, m_flg});
    check("done", {31'h0, done}, {31'h0, ok});
    check("cmd_error", {31'h0, cmd_error}, {31'h0, !ok});
  endtask : issue

  task automatic t_ranges();
    load(32'h0000_0100);
    issue(O_OR, A_IN, 11'o10, 6'h4, 32'h0, 32'hffff_ffff);
    issue(O_OR, A_IN, 11'o0, 6'h1, 32'h0, 32'hffff_fffe);
    issue(O_OR, A_IN, 11'o0, 6'h20, 32'h0, 32'h8000_0000);
    load(32'h0000_00f0);
    issue(O_XR, A_IN, 11'o0, 6'h8, 32'h0, 32'hffff_fff0);
    issue(O_XR, A_IN, 11'o0, 6'h0, 32'h0, 32'h1);
    issue(O_XR, A_IN, 11'o0, 6'h21, 32'h0, 32'h1);
    issue(O_NO, A_IN, 11'o0, 6'h1, 32'h1, 32'h1);
    for (int a = 0; a < 7; a++) begin
      issue(O_XR, plu_pkg::plu_area_t'(a), lim(plu_pkg::plu_area_t'(a)), 6'h1, 32'h0, 32'h1);
      issue(O_OR, plu_pkg::plu_area_t'(a), lim(plu_pkg::plu_area_t'(a)) + 11'h1, 6'h1, 32'h0,
            32'h2);
    end
    $display("t_ranges finished");
  endtask : t_ranges

  task automatic t_stack();
    for (int i = 1; i <= 2; i++) begin
      load(32'(i));
      @(posedge sys_clk);
      stack_push <= 1'b1;
      @(posedge sys_clk);
      stack_push <= 1'b0;
      stk.push_front(m_acc);
    end
    load(32'h8000_0000);
    issue(O_OS, A_IN, 11'o0, 6'h0, 32'h0, 32'h0);
    @(posedge sys_clk);
    #1;
    check("stack_top", stack_top, 32'h1);
    issue(O_OS, A_IN, 11'o0, 6'h0, 32'h0, 32'h0);
    $display("t_stack finished");
  endtask : t_stack

  task automatic t_xor();
    load(32'h8000_1234);
    issue(O_XW, A_IN, 11'o0, 6'h0, 32'hffff_1234, 32'h0);
    load(32'h0000_5a5a);
    issue(O_XW, A_IN, 11'o0, 6'h0, 32'h1234_5a5a, 32'h0);
    load(32'h3647_6a38);
    check("flags_hold", {30'h0, flags}, {30'h0, m_flg});
    issue(O_XD, A_IN, 11'o0, 6'h0, 32'h3647_6a38, 32'h0);
    issue(O_XD, A_IN, 11'o0, 6'h0, 32'hffff_ffff, 32'h0);
    $display("t_xor finished");
  endtask : t_xor

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    {rst_b, cmd_valid, acc_load, stack_push} = 4'h0;
    cmd = '0;
    disc_bits = 32'h0;
    acc_load_value = 32'h0;
    {m_acc, m_flg} = '0;
    fails = 0;
    samples_checked = 0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_ranges();
    t_stack();
    t_xor();
    report_and_stop();
  end
endmodule : plu_logic_op_unit_tb_top
